//--- lvd_defines.vh
`ifndef LVD_DEFINES_VH
`define LVD_DEFINES_VH
`define LVD_CLK_HZ        50000000
`define LVD_MS_PER_S      1000
`define LVD_MS_CYC        (`LVD_CLK_HZ / `LVD_MS_PER_S)
`define LVD_SLOT_MS       5
`define LVD_PRES_HOLD_MS  240000
`define LVD_PULSE_MS      125
`define LVD_TUNE_MS       2000
`define LVD_FLASH_PER_MS  1000
`define LVD_FLASH_ON_MS   500
`define LVD_PRIOR_ON_MS   50
`define LVD_PRIOR_GAP_MS  333
`define LVD_GREEN_MS      750
`define LVD_PAT_MS        (`LVD_FLASH_PER_MS + `LVD_GREEN_MS)
`define LVD_L_MIN         16'h0100
`define LVD_L_MAX         16'hF000
`define LVD_L_OPEN        16'hFFFF
`define LVD_TEST_MIN      16'h0400
`define LVD_TEST_MAX      16'hE000
`define LVD_SENS_BASE     4
`define LVD_CFG_W         6
`endif

//--- lvd_loop_detector.v
`timescale 1ns/1ns
`include "lvd_defines.vh"
// What this block does
// - excite the two loops alternately, never together; take one sample per activation
// - compare sample to baseline in size and rate; follow slow drift without a call
// - rapid drop beyond the sensitivity threshold raises the channel call
// - out-of-range or a jump over 25 percent enters loop-failure behaviour
// - during failure, fail-safe holds call on, fail-secure holds it off
// - open loop or upward jump shows steady red while it lasts
// - shorted loop or downward jump flashes red at one hertz
// - after recovery detect normally, flash red three 50 ms pulses per second
// - prior-failure memory stays latched until manual reset, power loss or a switch change that resets the channel
// - with no failure history an active call shows green
// - call with prior failure: three short red flashes then 750 ms green
// - self-test exercises indicators, outputs and each frequency selection range
// - outside self-test a disabled channel gives no call and its oscillator is not excited
// - changing disable, fail mode, output mode or sensitivity resets only that channel
// - two-bit field picks one of four oscillator frequencies per channel
// - fail-secure also picks the faster response timing
// - presence mode holds an occupied call at least four minutes
// - pulse mode emits one 125 ms pulse per entering vehicle
// - pulse mode tunes out a vehicle staying over two seconds
// - pulse mode regains full sensitivity within one second of departure
// - three-bit field picks one of eight sensitivities, each step doubling
module lvd_loop_detector #(
  parameter MS_CYC       = `LVD_MS_CYC,
  parameter PRES_HOLD_MS = `LVD_PRES_HOLD_MS,
  parameter TUNE_MS      = `LVD_TUNE_MS,
  parameter PULSE_MS     = `LVD_PULSE_MS,
  parameter SLOT_MS      = `LVD_SLOT_MS
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [1:0]  sw_disable,
  input  wire [3:0]  sw_freq,
  input  wire [1:0]  sw_fail_secure,
  input  wire [1:0]  sw_pulse_mode,
  input  wire [5:0]  sw_sens,
  input  wire        test_mode,
  input  wire [15:0] loop_sample,
  input  wire        loop_sample_vld,
  output wire [1:0]  osc_en,
  output wire [3:0]  osc_freq,
  output reg  [1:0]  call_out,
  output reg  [1:0]  led_red,
  output reg  [1:0]  led_grn,
  output reg  [1:0]  loop_fail,
  output reg  [1:0]  prior_fail,
  output reg  [1:0]  test_err
);
  reg  [15:0] ms_cnt_q;
  reg         ms_tick_q;
  reg  [9:0]  ph_1s_q;
  reg  [10:0] ph_pat_q;
  reg         act_ch_q;
  reg  [7:0]  slot_ms_q;
  reg  [15:0] samp_q;
  reg         samp_vld_q;
  reg         samp_ch_q;
  reg  [1:0]  tfreq_q;
  wire        slot_end;
  wire        act_on;
  wire        half_on;
  wire        prior_on;
  wire        grn_win;
  // the load value is cut to the width of the pulse timer on purpose
  wire [31:0] pulse_ld = PULSE_MS;

  function prior_flash;
    input [9:0] ph;
    begin
      prior_flash = (ph < `LVD_PRIOR_ON_MS) ||
                    (ph >= `LVD_PRIOR_GAP_MS && ph < `LVD_PRIOR_GAP_MS + `LVD_PRIOR_ON_MS) ||
                    (ph >= 2 * `LVD_PRIOR_GAP_MS &&
                     ph < 2 * `LVD_PRIOR_GAP_MS + `LVD_PRIOR_ON_MS);
    end
  endfunction

  // one tick per millisecond feeds every timer and flash pattern
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ms_cnt_q  <= 16'h0000;
      ms_tick_q <= 1'b0;
      ph_1s_q   <= 10'h000;
      ph_pat_q  <= 11'h000;
    end
    else
    begin
      ms_tick_q <= (ms_cnt_q == MS_CYC - 1);
      ms_cnt_q  <= (ms_cnt_q == MS_CYC - 1) ? 16'h0000 : ms_cnt_q + 16'h0001;
      if (ms_tick_q)
      begin
        ph_1s_q  <= (ph_1s_q == `LVD_FLASH_PER_MS - 1) ? 10'h000 : ph_1s_q + 10'h001;
        ph_pat_q <= (ph_pat_q == `LVD_PAT_MS - 1) ? 11'h000 : ph_pat_q + 11'h001;
      end
    end
  end

  assign half_on  = (ph_1s_q < `LVD_FLASH_ON_MS);
  assign prior_on = prior_flash(ph_1s_q);
  assign grn_win  = (ph_pat_q >= `LVD_FLASH_PER_MS);
  wire [9:0] pat_ph = grn_win ? 10'h000 : ph_pat_q[9:0];

  // a single active slot at a time keeps the two loop fields from coupling
  assign act_on   = test_mode | ~sw_disable[act_ch_q];
  assign osc_en   = act_on ? (act_ch_q ? 2'b10 : 2'b01) : 2'b00;
  assign osc_freq = test_mode ? {tfreq_q, tfreq_q} : sw_freq;
  assign slot_end = (act_on & loop_sample_vld) | (ms_tick_q & (slot_ms_q == SLOT_MS - 1));

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      act_ch_q   <= 1'b0;
      slot_ms_q  <= 8'h00;
      samp_q     <= 16'h0000;
      samp_vld_q <= 1'b0;
      samp_ch_q  <= 1'b0;
      tfreq_q    <= 2'b00;
    end
    else
    begin
      samp_vld_q <= slot_end & act_on;
      if (slot_end)
      begin
        // a loop that never oscillates reads as the highest inductance, i.e. open
        samp_q    <= loop_sample_vld ? loop_sample : `LVD_L_OPEN;
        samp_ch_q <= act_ch_q;
        act_ch_q  <= ~act_ch_q;
        slot_ms_q <= 8'h00;
        if (test_mode && act_ch_q)
          tfreq_q <= tfreq_q + 2'b01;
      end
      else if (ms_tick_q)
        slot_ms_q <= slot_ms_q + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
      reg  [`LVD_CFG_W-1:0] cfg_q;
      reg  [15:0] base_q;
      reg         base_vld_q;
      reg         det_q;
      reg  [1:0]  hit_q;
      reg  [17:0] occ_ms_q;
      reg  [7:0]  pulse_ms_q;
      reg         fail_q;
      reg         fail_up_q;
      reg         tuned_q;
      wire [`LVD_CFG_W-1:0] cfg = {sw_disable[g], sw_fail_secure[g], sw_pulse_mode[g],
                                   sw_sens[3*g+2:3*g]};
      wire        crst = (cfg != cfg_q) & ~test_mode;
      wire        stb  = samp_vld_q & (samp_ch_q == g) & ~test_mode;
      wire [15:0] s    = samp_q;
      wire [16:0] up_lim = {1'b0, base_q} + {3'b000, base_q[15:2]};
      wire [15:0] dn_lim = base_q - {2'b00, base_q[15:2]};
      wire        f_open = (s > `LVD_L_MAX) | (base_vld_q & ({1'b0, s} > up_lim));
      wire        f_shrt = (s < `LVD_L_MIN) | (base_vld_q & (s < dn_lim));
      // each level up halves the threshold, so sensitivity doubles
      wire [15:0] thr  = base_q >> (`LVD_SENS_BASE + sw_sens[3*g+2:3*g]);
      wire        veh  = base_vld_q & (base_q > s) & ((base_q - s) > thr);
      wire [1:0]  need = sw_fail_secure[g] ? 2'd1 : 2'd2;
      // next call value, so the green lamp rises with the call and not a cycle behind
      wire        call_nx = sw_disable[g] ? 1'b0 :
                            fail_q ? ~sw_fail_secure[g] :
                            sw_pulse_mode[g] ? (pulse_ms_q != 8'h00) : det_q;

      always @(posedge ref_clk)
      begin
        if (!rst_n || crst)
        begin
          cfg_q      <= cfg;
          base_q     <= 16'h0000;
          base_vld_q <= 1'b0;
          det_q      <= 1'b0;
          hit_q      <= 2'd0;
          occ_ms_q   <= 18'h00000;
          pulse_ms_q <= 8'h00;
          fail_q     <= 1'b0;
          fail_up_q  <= 1'b0;
          tuned_q    <= 1'b0;
          prior_fail[g] <= 1'b0;
        end
        else
        begin
          if (ms_tick_q && pulse_ms_q != 8'h00)
            pulse_ms_q <= pulse_ms_q - 8'h01;
          if (ms_tick_q && det_q && occ_ms_q != 18'h3FFFF)
            occ_ms_q <= occ_ms_q + 18'h00001;
          if (fail_q)
            prior_fail[g] <= 1'b1;
          if (stb)
          begin
            if (!base_vld_q)
            begin
              base_q     <= s;
              base_vld_q <= (s <= `LVD_L_MAX) && (s >= `LVD_L_MIN);
              fail_q     <= (s > `LVD_L_MAX) || (s < `LVD_L_MIN);
              fail_up_q  <= (s > `LVD_L_MAX);
            end
            else if (f_open || f_shrt)
            begin
              fail_q    <= 1'b1;
              fail_up_q <= f_open;
              det_q     <= 1'b0;
              hit_q     <= 2'd0;
            end
            else
            begin
              fail_q <= 1'b0;
              if (veh && !tuned_q)
              begin
                hit_q <= (hit_q == 2'd3) ? hit_q : hit_q + 2'd1;
                if (!det_q && hit_q + 2'd1 >= need)
                begin
                  det_q      <= 1'b1;
                  occ_ms_q   <= 18'h00000;
                  pulse_ms_q <= pulse_ld[7:0];
                end
              end
              else
              begin
                hit_q <= 2'd0;
                det_q <= 1'b0;
              end
              if (!veh)
                tuned_q <= 1'b0;
              if (det_q && sw_pulse_mode[g] && occ_ms_q >= TUNE_MS)
              begin
                base_q  <= s;
                det_q   <= 1'b0;
                tuned_q <= 1'b1;
              end
              else if (sw_pulse_mode[g] && s > base_q)
                base_q <= s;
              else if (det_q && occ_ms_q >= PRES_HOLD_MS && base_q > s)
                base_q <= base_q - 16'h0001;
              else if (!det_q && s > base_q)
                base_q <= base_q + 16'h0001;
              else if (!det_q && s < base_q && !veh)
                base_q <= base_q - 16'h0001;
            end
          end
        end
      end

      always @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          call_out[g]  <= 1'b0;
          led_red[g]   <= 1'b0;
          led_grn[g]   <= 1'b0;
          loop_fail[g] <= 1'b0;
          test_err[g]  <= 1'b0;
        end
        else if (test_mode)
        begin
          // test walks outputs and both lamp colours; red stays on when a range fails
          if (samp_vld_q && samp_ch_q == g &&
              (samp_q < `LVD_TEST_MIN || samp_q > `LVD_TEST_MAX))
            test_err[g] <= 1'b1;
          call_out[g] <= half_on;
          led_red[g]  <= test_err[g] | ~half_on;
          led_grn[g]  <= ~test_err[g] & half_on & ~sw_disable[g];
        end
        else
        begin
          test_err[g]  <= 1'b0;
          loop_fail[g] <= fail_q;
          if (sw_disable[g])
            call_out[g] <= 1'b0;
          else if (fail_q)
            call_out[g] <= ~sw_fail_secure[g];
          else if (sw_pulse_mode[g])
            call_out[g] <= (pulse_ms_q != 8'h00);
          else
            call_out[g] <= det_q;
          if (fail_q)
          begin
            led_red[g] <= fail_up_q ? 1'b1 : half_on;
            led_grn[g] <= 1'b0;
          end
          else if (prior_fail[g] && det_q)
          begin
            led_red[g] <= ~grn_win & prior_flash(pat_ph);
            led_grn[g] <= grn_win;
          end
          else if (prior_fail[g])
          begin
            led_red[g] <= prior_on;
            led_grn[g] <= 1'b0;
          end
          else
          begin
            led_red[g] <= 1'b0;
            led_grn[g] <= call_nx & ~sw_disable[g];
          end
        end
      end
    end
  endgenerate

endmodule // lvd_loop_detector

//--- lvd_checker.sv
`timescale 1ns/1ns
module lvd_checker #(
  parameter MS_CYC   = 10,
  parameter PULSE_MS = 5
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [1:0]  sw_disable,
  input wire [3:0]  sw_freq,
  input wire [1:0]  sw_fail_secure,
  input wire [1:0]  sw_pulse_mode,
  input wire [5:0]  sw_sens,
  input wire        test_mode,
  input wire [15:0] loop_sample,
  input wire        loop_sample_vld,
  input wire [1:0]  osc_en,
  input wire [3:0]  osc_freq,
  input wire [1:0]  call_out,
  input wire [1:0]  led_red,
  input wire [1:0]  led_grn,
  input wire [1:0]  loop_fail,
  input wire [1:0]  prior_fail,
  input wire [1:0]  test_err
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam int LO = MS_CYC * PULSE_MS - MS_CYC;
  localparam int HI = MS_CYC * PULSE_MS + MS_CYC;
  reg [15:0] hi_q;
  // length of the current high run of the ch0 call
  always @(posedge ref_clk) hi_q <= call_out[0] ? hi_q + 16'h0001 : 16'h0000;
  sequence took;
    loop_sample_vld && osc_en != 2'h0;
  endsequence
  // a switch change resets the channel one or two edges late, so demand calm
  sequence quiet0;
    !test_mode && $stable(sw_disable[0]) && $stable(sw_fail_secure[0])
      && $stable(sw_pulse_mode[0]) && $stable(sw_sens[2:0]);
  endsequence
  sequence held0;
    quiet0 ##0 prior_fail[0];
  endsequence
  AST_ONE_HOT: assert property (osc_en != 2'h3) else $error("both loops excited");
  AST_SWAP: assert property (took |=> (osc_en & $past(osc_en)) == 2'h0)
    else $error("excitation did not move on");
  AST_DIS_OSC: assert property (sw_disable[1] && !test_mode |-> !osc_en[1])
    else $error("disabled loop excited");
  AST_DIS_CALL: assert property ((sw_disable[1] && !test_mode)[*4] |-> !call_out[1])
    else $error("disabled channel calls");
  AST_SAFE: assert property ((loop_fail[0] && !sw_fail_secure[0] && !test_mode)[*2]
    |-> call_out[0]) else $error("fail-safe call missing");
  AST_SECURE: assert property ((loop_fail[1] && sw_fail_secure[1] && !test_mode)[*2]
    |-> !call_out[1]) else $error("fail-secure call present");
  AST_PRIOR: assert property (held0 ##1 held0 ##1 quiet0 |-> prior_fail[0])
    else $error("prior failure memory lost");
  AST_GRN: assert property (quiet0[*4] ##0 (call_out[0] && !prior_fail[0] && !loop_fail[0])
    |-> led_grn[0]) else $error("call without green");
  AST_PULSE: assert property ($fell(call_out[0]) && sw_pulse_mode[0] && !test_mode
    && !loop_fail[0] |-> hi_q > LO && hi_q < HI) else $error("pulse width wrong");
  AST_TST: assert property (!test_mode ##1 !test_mode |-> test_err == 2'h0)
    else $error("test error outside test");
endmodule // lvd_checker
bind lvd_loop_detector lvd_checker #(.MS_CYC(MS_CYC), .PULSE_MS(PULSE_MS)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .sw_disable(sw_disable), .sw_freq(sw_freq),
  .sw_fail_secure(sw_fail_secure), .sw_pulse_mode(sw_pulse_mode), .sw_sens(sw_sens),
  .test_mode(test_mode), .loop_sample(loop_sample), .loop_sample_vld(loop_sample_vld),
  .osc_en(osc_en), .osc_freq(osc_freq), .call_out(call_out), .led_red(led_red),
  .led_grn(led_grn), .loop_fail(loop_fail), .prior_fail(prior_fail), .test_err(test_err));

//--- lvd_loop_model.sv
`timescale 1ns/1ns
module lvd_loop_model (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [1:0]  osc_en,
  input  wire [15:0] val0,
  input  wire [15:0] val1,
  input  wire [7:0]  dly,
  output reg  [15:0] loop_sample = 16'h5A5A,
  output reg         loop_sample_vld = 1'b0
);
  reg [7:0] cnt_q = 8'h00;
  reg [1:0] en_q = 2'h0;
  always @(posedge ref_clk)
  begin
    en_q <= osc_en;
    loop_sample_vld <= 1'b0;
    // word is only held with valid; otherwise it keeps toggling
    loop_sample <= ~loop_sample;
    if (!rst_n || osc_en != en_q || loop_sample_vld)
      cnt_q <= 8'h00;
    else if (osc_en != 2'h0)
    begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == dly)
      begin
        loop_sample_vld <= 1'b1;
        loop_sample <= osc_en[1] ? val1 : val0;
      end
    end
  end
endmodule // lvd_loop_model

//--- tb_lvd_loop_detector.sv
`timescale 1ns/1ns
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_lvd_loop_detector;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         test_mode = 1'b0;
  reg  [1:0]  sw_disable = 2'h0, sw_fail_secure = 2'h0, sw_pulse_mode = 2'h0;
  reg  [3:0]  sw_freq = 4'h0;
  reg  [5:0]  sw_sens = 6'h08;
  reg  [15:0] v0 = 16'h8000, v1 = 16'h8000;
  reg  [7:0]  dly = 8'h01;
  wire [15:0] loop_sample;
  wire        loop_sample_vld;
  wire [1:0]  osc_en, call_out, led_red, led_grn, loop_fail, prior_fail, test_err;
  wire [3:0]  osc_freq;
  int         errors = 0, num_checks = 0, r, g;
  lvd_loop_detector #(.MS_CYC(10), .PRES_HOLD_MS(50), .TUNE_MS(40), .PULSE_MS(5),
    .SLOT_MS(2)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .sw_disable(sw_disable),
    .sw_freq(sw_freq), .sw_fail_secure(sw_fail_secure), .sw_pulse_mode(sw_pulse_mode),
    .sw_sens(sw_sens), .test_mode(test_mode), .loop_sample(loop_sample),
    .loop_sample_vld(loop_sample_vld), .osc_en(osc_en), .osc_freq(osc_freq),
    .call_out(call_out), .led_red(led_red), .led_grn(led_grn), .loop_fail(loop_fail),
    .prior_fail(prior_fail), .test_err(test_err));
  lvd_loop_model u_loop (.ref_clk(ref_clk), .rst_n(rst_n), .osc_en(osc_en), .val0(v0),
    .val1(v1), .dly(dly), .loop_sample(loop_sample), .loop_sample_vld(loop_sample_vld));
  initial forever #10 ref_clk = ~ref_clk;
  task tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // waits whole ms, then settles to the falling edge for sampling
  task ms(input int n);
    repeat (n * 10) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task put(input [15:0] a, input [15:0] b);
    @(posedge ref_clk);
    v0 <= a;
    v1 <= b;
    ms(5);
  endtask
  task leds(input int n);
    r = 0;
    g = 0;
    repeat (n * 10)
    begin
      @(negedge ref_clk);
      r += led_red[0];
      g += led_grn[0];
    end
  endtask
  initial
  begin
    #2000000;
    errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (15) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(osc_en, 2'h1)
    `CHK({call_out, led_red, led_grn, loop_fail, prior_fail}, 10'h000)
    @(posedge ref_clk);
    rst_n <= 1'b1;
    put(16'h8010, 16'h8010);
    `CHK(call_out, 2'h0)
    put(16'h7A00, 16'h7A00);
    `CHK(call_out, 2'h2)
    `CHK(led_grn, 2'h2)
    ms(45);
    `CHK(call_out[1], 1'b1)
    put(16'hFFFF, 16'h8010);
    `CHK({loop_fail, call_out, led_red}, 6'h15)
    put(16'h8010, 16'h8010);
    `CHK({loop_fail[0], prior_fail[0], call_out[0]}, 3'h2)
    leds(1000);
    `CHK(r, 1500)
    put(16'h6400, 16'h8010);
    leds(1750);
    `CHK(r, 1500)
    `CHK(g, 7500)
    put(16'h0010, 16'h8010);
    `CHK(loop_fail[0], 1'b1)
    leds(1000);
    `CHK(r, 5000)
    @(posedge ref_clk);
    sw_disable <= 2'h2;
    ms(5);
    `CHK({osc_en[1], call_out[1], prior_fail[0]}, 3'h1)
    @(posedge ref_clk);
    sw_freq <= 4'hB;
    ms(1);
    `CHK(osc_freq, 4'hB)
    @(posedge ref_clk);
    sw_disable <= 2'h0;
    sw_fail_secure <= 2'h2; // this switch change is the reset due after retuning
    put(16'h8010, 16'h8010);
    put(16'h8010, 16'hFFFF);
    `CHK({loop_fail[1], call_out[1]}, 2'h2)
    @(posedge ref_clk);
    sw_pulse_mode <= 2'h1;
    ms(5);
    `CHK(prior_fail[0], 1'b0)
    put(16'h7000, 16'hFFFF);
    `CHK(call_out[0], 1'b1)
    ms(5);
    `CHK(call_out[0], 1'b0)
    ms(40);
    put(16'h6000, 16'hFFFF);
    `CHK(call_out[0], 1'b1)
    put(16'h8010, 16'hFFFF);
    put(16'h7000, 16'hFFFF);
    `CHK(call_out[0], 1'b1)
    ms(10);
    @(posedge ref_clk);
    sw_pulse_mode <= 2'h0;
    // in-range words first, so no sample in flight at test entry reads as a fault
    put(16'h8000, 16'h8000);
    @(posedge ref_clk);
    test_mode <= 1'b1;
    put(16'h8000, 16'h8000);
    `CHK(test_err, 2'h0)
    put(16'h0200, 16'h8000);
    `CHK(test_err, 2'h1)
    `CHK(led_red[0], 1'b1)
    @(posedge ref_clk);
    test_mode <= 1'b0;
    ms(1);
    `CHK(test_err, 2'h0)
    tally_and_finish;
  end
endmodule // tb_lvd_loop_detector
